/* hw/uart_txrx_pkg.sv */
// shared constants, register map and state types for the uart control block
package uart_txrx_pkg;
    // register indexes on the plain register port
    localparam logic [2:0] ctrl_one_addr = 3'h0;
    localparam logic [2:0] ctrl_two_addr = 3'h1;
    localparam logic [2:0] ctrl_three_addr = 3'h2;
    localparam logic [2:0] status_addr = 3'h3;
    localparam logic [2:0] data_addr = 3'h4;
    // control one fields
    localparam int global_on_pos = 7;
    localparam int data_length_pos = 6;
    localparam int tx_ninth_pos = 0;
    // control two fields
    localparam int tx_on_pos = 7;
    localparam int rx_on_pos = 6;
    localparam int stop_sel_pos = 5;
    localparam int addr_det_pos = 4;
    localparam int wake_on_pos = 3;
    localparam int rx_irq_pos = 2;
    localparam int idle_irq_pos = 1;
    localparam int empty_irq_pos = 0;
    // control three fields
    localparam int single_wire_pos = 0;
    localparam int wake_irq_pos = 1;
    // status fields
    localparam int st_empty_pos = 0;
    localparam int st_idle_pos = 1;
    localparam int st_avail_pos = 2;
    localparam int st_overrun_pos = 3;
    localparam int st_wake_pos = 4;
    localparam int st_ninth_pos = 5;
    // reset values
    localparam logic [7:0] ctrl_one_reset = 8'h00;
    localparam logic [7:0] ctrl_two_reset = 8'h00;
    localparam logic [7:0] ctrl_three_reset = 8'h00;
    // uart clock cycles per bit, baud generator lies outside this block
    localparam int bit_cycles_default = 16;
    localparam int min_bit_cycles = 4;
    typedef enum logic [1:0] {
        ser_idle = 2'b00,
        ser_start = 2'b01,
        ser_data = 2'b10,
        ser_stop = 2'b11
    } ser_state_type;
endpackage

/* hw/uart_rx_deframer.sv */
// serial receive deframer: start check, 8 or 9 data bits, stop check
module uart_rx_deframer
    import uart_txrx_pkg::*;
#(
    parameter int bit_cycles = bit_cycles_default
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // control
    input wire logic enable_in,
    input wire logic nine_in,
    // synchronised line
    input wire logic line_in,
    // received word
    output logic word_valid_out,
    output logic [8:0] word_out
);
    localparam int cw = $clog2(bit_cycles);
    localparam logic [cw-1:0] full_count = cw'(bit_cycles - 1);
    localparam logic [cw-1:0] half_count = cw'(bit_cycles / 2 - 1);

    ser_state_type state;
    logic [cw-1:0] tick;
    logic [3:0] bit_idx;
    logic [8:0] shift;

    initial begin
        if (bit_cycles < min_bit_cycles) begin
            $error("bit_cycles too small");
        end
    end

    // a disabled receiver drops any word in progress
    always_ff @(posedge mclk_in) begin
        word_valid_out <= 1'b0;
        if (srst_in || !enable_in) begin
            state <= ser_idle;
            tick <= '0;
            bit_idx <= 4'h0;
            shift <= 9'h000;
            word_out <= 9'h000;
        end else begin
            tick <= tick + cw'(1);
            case (state)
                ser_idle: begin
                    tick <= '0;
                    if (!line_in) begin
                        state <= ser_start;
                    end
                end
                ser_start: begin
                    // glitch shorter than half a bit is ignored
                    if (tick == half_count) begin
                        tick <= '0;
                        bit_idx <= 4'h0;
                        state <= line_in ? ser_idle : ser_data;
                    end
                end
                ser_data: begin
                    if (tick == full_count) begin
                        tick <= '0;
                        shift <= {line_in, shift[8:1]};
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx == (nine_in ? 4'h8 : 4'h7)) begin
                            state <= ser_stop;
                        end
                    end
                end
                default: begin
                    if (tick == full_count) begin
                        state <= ser_idle;
                        // framing errors are dropped silently
                        if (line_in) begin
                            word_valid_out <= 1'b1;
                            word_out <= nine_in ? shift : {1'b0, shift[8:1]};
                        end
                    end
                end
            endcase
        end
    end
endmodule

/* hw/uart_txrx_control.sv */
// uart second control register with transmitter, receive path, wake-up and irq
// Functional notes
// - tx enable low aborts and floats transmitter
// - tx pin driven only with both enables
// - rx enable low aborts, resets receive buffer
// - receiver runs only with both enables
// - stop-count bit picks one or two stop_bit_count_select
// - address bit set marks word as address
// - accepted address word raises receiver irq
// - address bit clear discards word, no irq
// - wake bit, clock stopped: falling edge requests
// - no pin wake while uart clock runs
// - wake request raises irq when enabled
// - wake bit clear: edge never resumes
// - receiver irq enable gates overrun and available
// - idle irq enable gates transmitter idle
// - empty irq enable gates transmitter empty
// - global off flushes, clears receive and wake flags and the tx and rx enables
// - length bit picks 8 or 9 bits
// - single wire, both enables: pin receives only
module uart_txrx_control
    import uart_txrx_pkg::*;
#(
    parameter int bit_cycles = bit_cycles_default
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // serial pins
    output logic tx_out,
    output logic tx_oe_out,
    input wire logic rxtx_in,
    output logic rxtx_out,
    output logic rxtx_oe_out,
    // power and interrupt
    input wire logic uart_clock_off_in,
    output logic wake_request_out,
    output logic irq_out
);
    localparam int cw = $clog2(bit_cycles);
    localparam logic [cw-1:0] full_count = cw'(bit_cycles - 1);

    logic global_serial_on;
    logic data_length_select;
    logic transmit_ninth_bit;
    logic [7:0] uart_control_two;
    logic single_wire_select;
    logic wake_irq_on;
    logic transmitter_on;
    logic receiver_on;
    logic stop_bit_count_select;
    logic address_detect_on;
    logic wake_on;
    logic receiver_irq_on;
    logic tx_idle_irq_on;
    logic tx_empty_irq_on;
    logic tx_run;
    logic rx_enabled;
    logic rx_run;
    logic wr_hit_one;
    logic wr_hit_two;
    logic wr_hit_data;
    logic rd_hit_status;
    logic rd_hit_data;
    logic hold_full;
    logic [8:0] hold_data;
    ser_state_type tx_state;
    logic [cw-1:0] tx_tick;
    logic tx_bit_done;
    logic [3:0] tx_bit_idx;
    logic [8:0] tx_shift;
    logic stop_bit_count_select_left;
    logic tx_line;
    logic transmitter_empty_flag;
    logic transmitter_idle_flag;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic word_valid;
    logic [8:0] word;
    logic address_bit;
    logic word_accept;
    logic [7:0] rx_data;
    logic received_ninth_bit;
    logic rx_data_available_flag;
    logic overrun_flag;
    logic wake_flag;
    logic wake_edge;
    logic next_irq;
    logic [7:0] next_rdata;
    logic [15:0] stop_len;
    logic stop_two_seen;

    // position of the last data bit in a frame
    function automatic logic [3:0] frame_last(input logic nine);
        frame_last = nine ? 4'h8 : 4'h7;
    endfunction

    initial begin
        if (bit_cycles < min_bit_cycles) begin
            $error("bit_cycles too small");
        end
    end

    assign transmitter_on = uart_control_two[tx_on_pos];
    assign receiver_on = uart_control_two[rx_on_pos];
    assign stop_bit_count_select = uart_control_two[stop_sel_pos];
    assign address_detect_on = uart_control_two[addr_det_pos];
    assign wake_on = uart_control_two[wake_on_pos];
    assign receiver_irq_on = uart_control_two[rx_irq_pos];
    assign tx_idle_irq_on = uart_control_two[idle_irq_pos];
    assign tx_empty_irq_on = uart_control_two[empty_irq_pos];

    assign wr_hit_one = reg_wr_in && (reg_addr_in == ctrl_one_addr);
    assign wr_hit_two = reg_wr_in && (reg_addr_in == ctrl_two_addr);
    assign wr_hit_data = reg_wr_in && (reg_addr_in == data_addr);
    assign rd_hit_status = reg_rd_in && (reg_addr_in == status_addr);
    assign rd_hit_data = reg_rd_in && (reg_addr_in == data_addr);

    assign tx_run = global_serial_on && transmitter_on;
    assign rx_enabled = global_serial_on && receiver_on;
    // a stopped uart clock also stop_bit_count_select the receiver
    assign rx_run = rx_enabled && !uart_clock_off_in;

    // control one and three
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            global_serial_on <= ctrl_one_reset[global_on_pos];
            data_length_select <= ctrl_one_reset[data_length_pos];
            transmit_ninth_bit <= ctrl_one_reset[tx_ninth_pos];
            single_wire_select <= ctrl_three_reset[single_wire_pos];
            wake_irq_on <= ctrl_three_reset[wake_irq_pos];
        end else begin
            if (wr_hit_one) begin
                global_serial_on <= reg_wdata_in[global_on_pos];
                data_length_select <= reg_wdata_in[data_length_pos];
                transmit_ninth_bit <= reg_wdata_in[tx_ninth_pos];
            end
            if (reg_wr_in && (reg_addr_in == ctrl_three_addr)) begin
                single_wire_select <= reg_wdata_in[single_wire_pos];
                wake_irq_on <= reg_wdata_in[wake_irq_pos];
            end
        end
    end

    // control two, enables forced low while the uart is off
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            uart_control_two <= ctrl_two_reset;
        end else begin
            if (wr_hit_two) begin
                uart_control_two <= reg_wdata_in;
            end
            if (!global_serial_on) begin
                uart_control_two[tx_on_pos] <= 1'b0;
                uart_control_two[rx_on_pos] <= 1'b0;
            end
        end
    end

    // transmit holding register, writes while full are ignored
    always_ff @(posedge mclk_in) begin
        if (srst_in || !tx_run) begin
            hold_full <= 1'b0;
            hold_data <= 9'h000;
        end else if (tx_state == ser_idle && hold_full) begin
            hold_full <= 1'b0;
        end else if (wr_hit_data && !hold_full) begin
            hold_full <= 1'b1;
            hold_data <= {transmit_ninth_bit, reg_wdata_in};
        end
    end

    assign tx_bit_done = (tx_tick == full_count);

    // transmit shifter
    always_ff @(posedge mclk_in) begin
        if (srst_in || !tx_run) begin
            tx_state <= ser_idle;
            tx_tick <= '0;
            tx_bit_idx <= 4'h0;
            tx_shift <= 9'h000;
            stop_bit_count_select_left <= 1'b0;
            tx_line <= 1'b1;
        end else begin
            tx_tick <= tx_bit_done ? '0 : tx_tick + cw'(1);
            case (tx_state)
                ser_idle: begin
                    tx_tick <= '0;
                    if (hold_full) begin
                        tx_shift <= hold_data;
                        tx_line <= 1'b0;
                        tx_state <= ser_start;
                    end
                end
                ser_start: begin
                    if (tx_bit_done) begin
                        tx_bit_idx <= 4'h0;
                        tx_line <= tx_shift[0];
                        tx_state <= ser_data;
                    end
                end
                ser_data: begin
                    if (tx_bit_done) begin
                        if (tx_bit_idx == frame_last(data_length_select)) begin
                            tx_line <= 1'b1;
                            stop_bit_count_select_left <= stop_bit_count_select;
                            tx_state <= ser_stop;
                        end else begin
                            tx_bit_idx <= tx_bit_idx + 4'h1;
                            tx_shift <= {1'b0, tx_shift[8:1]};
                            tx_line <= tx_shift[1];
                        end
                    end
                end
                default: begin
                    if (tx_bit_done) begin
                        if (stop_bit_count_select_left) begin
                            stop_bit_count_select_left <= 1'b0;
                        end else begin
                            tx_state <= ser_idle;
                        end
                    end
                end
            endcase
        end
    end

    // flags read back as set while the transmitter is off
    assign transmitter_empty_flag = !hold_full;
    assign transmitter_idle_flag = !hold_full && (tx_state == ser_idle);

    // pin drivers; in single wire mode the receiver owns the shared pin while receiver_on is set, else the transmitter drives it
    assign tx_out = tx_line;
    assign tx_oe_out = tx_run && !single_wire_select;
    assign rxtx_out = tx_line;
    assign rxtx_oe_out = tx_run && single_wire_select && !receiver_on;

    // shared pin synchroniser, first stage feeds only the second
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= rxtx_in;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    uart_rx_deframer #(
        .bit_cycles(bit_cycles)
    ) receiver (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .enable_in(rx_run),
        .nine_in(data_length_select),
        .line_in(rx_sync),
        .word_valid_out(word_valid),
        .word_out(word)
    );

    assign address_bit = data_length_select ? word[8] : word[7];
    assign word_accept = word_valid && (!address_detect_on || address_bit);

    // receive buffer; a new word beats a read in the same cycle
    always_ff @(posedge mclk_in) begin
        if (srst_in || !rx_enabled) begin
            rx_data_available_flag <= 1'b0;
            overrun_flag <= 1'b0;
            rx_data <= 8'h00;
            received_ninth_bit <= 1'b0;
        end else begin
            if (rd_hit_status) begin
                overrun_flag <= 1'b0;
            end
            if (rd_hit_data) begin
                rx_data_available_flag <= 1'b0;
            end
            if (word_accept) begin
                // overrun keeps the unread word, the new one is lost
                if (rx_data_available_flag && !rd_hit_data) begin
                    overrun_flag <= 1'b1;
                end else begin
                    rx_data <= word[7:0];
                    received_ninth_bit <= word[8];
                    rx_data_available_flag <= 1'b1;
                end
            end
        end
    end

    // falling edge only counts while the uart clock is stopped
    assign wake_edge = uart_clock_off_in && wake_on && rx_prev && !rx_sync;

    always_ff @(posedge mclk_in) begin
        if (srst_in || !global_serial_on) begin
            wake_flag <= 1'b0;
        end else if (wake_edge) begin
            wake_flag <= 1'b1;
        end else if (rd_hit_status) begin
            wake_flag <= 1'b0;
        end
    end
    assign wake_request_out = wake_flag;

    always_comb begin
        next_irq = 1'b0;
        if (receiver_irq_on && (overrun_flag || rx_data_available_flag)) begin
            next_irq = 1'b1;
        end
        if (tx_idle_irq_on && transmitter_idle_flag) begin
            next_irq = 1'b1;
        end
        if (tx_empty_irq_on && transmitter_empty_flag) begin
            next_irq = 1'b1;
        end
        if (wake_irq_on && wake_flag) begin
            next_irq = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= next_irq;
        end
    end

    // read data valid only in the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr_in == ctrl_one_addr) begin
            next_rdata[global_on_pos] = global_serial_on;
            next_rdata[data_length_pos] = data_length_select;
            next_rdata[tx_ninth_pos] = transmit_ninth_bit;
        end else if (reg_addr_in == ctrl_two_addr) begin
            next_rdata = uart_control_two;
        end else if (reg_addr_in == ctrl_three_addr) begin
            next_rdata[single_wire_pos] = single_wire_select;
            next_rdata[wake_irq_pos] = wake_irq_on;
        end else if (reg_addr_in == status_addr) begin
            next_rdata[st_empty_pos] = transmitter_empty_flag;
            next_rdata[st_idle_pos] = transmitter_idle_flag;
            next_rdata[st_avail_pos] = rx_data_available_flag;
            next_rdata[st_overrun_pos] = overrun_flag;
            next_rdata[st_wake_pos] = wake_flag;
            next_rdata[st_ninth_pos] = received_ninth_bit;
        end else if (reg_addr_in == data_addr) begin
            next_rdata = rx_data;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in || !reg_rd_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

    // stop length helper for checking
    always_ff @(posedge mclk_in) begin
        if (srst_in || tx_state != ser_stop) begin
            stop_len <= 16'h0000;
            stop_two_seen <= stop_bit_count_select;
        end else begin
            stop_len <= stop_len + 16'h0001;
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);

    sequence last_stop_tick;
        tx_run && tx_state == ser_stop && tx_bit_done && !stop_bit_count_select_left;
    endsequence

    a_tx_off_float: assert property (!tx_run |-> !tx_oe_out && !rxtx_oe_out)
        else $error("pins driven with transmitter off");
    a_tx_pin_drive: assert property (tx_run && !single_wire_select |-> tx_oe_out)
        else $error("tx pin not driven");
    a_rx_buffer_reset: assert property (!rx_enabled |=> !rx_data_available_flag)
        else $error("receive buffer kept while off");
    a_shared_pin_rx: assert property (receiver_on |-> !rxtx_oe_out)
        else $error("shared pin driven while receiving");
    a_stop_length: assert property (last_stop_tick |->
        stop_len == (stop_two_seen ? 16'(2 * bit_cycles - 1) : 16'(bit_cycles - 1)))
        else $error("wrong stop length");
    a_addr_accept: assert property (rx_enabled && word_valid && address_detect_on
        && address_bit |=> rx_data_available_flag)
        else $error("address word not kept");
    a_addr_irq: assert property (rx_enabled && word_valid && address_detect_on
        && address_bit && receiver_irq_on && !wr_hit_two |=> ##1 irq_out)
        else $error("no irq for address word");
    a_data_discard: assert property (word_valid && address_detect_on && !address_bit
        && !rx_data_available_flag |=> !rx_data_available_flag)
        else $error("data word not discarded");
    a_wake_set: assert property (global_serial_on && uart_clock_off_in && wake_on
        && $fell(rx_sync) |=> wake_request_out)
        else $error("wake edge missed");
    a_wake_running: assert property (!uart_clock_off_in && !wake_flag |=> !wake_flag)
        else $error("wake while clock runs");
    a_wake_irq: assert property (wake_irq_on && wake_flag |=> irq_out)
        else $error("wake irq missing");
    a_wake_off: assert property (!wake_on && !wake_flag |=> !wake_flag)
        else $error("wake with bit clear");
    a_rx_irq: assert property (receiver_irq_on && (overrun_flag || rx_data_available_flag)
        |=> irq_out)
        else $error("receiver irq missing");
    a_idle_irq: assert property (tx_idle_irq_on && transmitter_idle_flag |=> irq_out)
        else $error("idle irq missing");
    a_empty_irq: assert property (tx_empty_irq_on && transmitter_empty_flag |=> irq_out)
        else $error("empty irq missing");
    a_global_off: assert property (!global_serial_on |=> !transmitter_on && !receiver_on
        && !overrun_flag && transmitter_idle_flag && transmitter_empty_flag)
        else $error("global off did not reset");
    a_frame_bits: assert property (tx_state == ser_data |->
        tx_bit_idx <= frame_last(data_length_select))
        else $error("data bit index beyond frame");
    a_irq_masked: assert property (!receiver_irq_on && !tx_idle_irq_on && !tx_empty_irq_on
        && !wake_irq_on |=> !irq_out)
        else $error("irq with all sources masked");
endmodule

/* verification/uart_peer.sv */
// remote serial peer: sends frames on the shared pin, captures transmit frames
module uart_peer #(
    parameter int bit_cycles = 4
) (
    // clock
    input wire logic mclk_in,
    // transmit line as seen at the pin, floating reads as pulled high
    input wire logic tx_line_in,
    // drive onto the shared pin
    output logic line_out,
    // second stop position and data of the last captured frame
    output logic [8:0] got_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_out = 1'b1;
    // 8 bit frame, lsb first, one stop, line back to idle high after it
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (bit_cycles) @(posedge mclk_in);
        end
    endtask
    // second stop slot reads 0 when the next start follows one stop only
    always @(negedge tx_line_in) begin
        repeat (bit_cycles / 2 + bit_cycles) @(posedge mclk_in);
        for (int i = 0; i < 9; i++) begin
            got_out[i] <= tx_line_in;
            repeat (i == 7 ? 2 * bit_cycles : bit_cycles) @(posedge mclk_in);
        end
    end
endmodule

/* verification/uart_txrx_control_test.sv */
// bench for the uart control block: registers, serial peer, irq and wake
module uart_txrx_control_test import uart_txrx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int bc = 4;
    logic mclk_in, srst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic uart_clock_off_in = 1'b0, rd_seen = 1'b0;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00, rnd = 8'h3c, d;
    logic [7:0] reg_rdata_out, exp_q[$];
    logic tx_out, tx_oe_out, rxtx_in, rxtx_out, rxtx_oe_out, wake_request_out, irq_out;
    logic peer_line, tx_line;
    logic [8:0] got;
    int n_fail = 0, n_compared = 0, cyc = 0;
    assign tx_line = tx_oe_out ? tx_out : 1'b1;
    assign rxtx_in = rxtx_oe_out ? rxtx_out : peer_line;
    uart_txrx_control #(.bit_cycles(bc)) u_uart_txrx_control (.mclk_in(mclk_in),
        .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .tx_out(tx_out), .tx_oe_out(tx_oe_out), .rxtx_in(rxtx_in), .rxtx_out(rxtx_out),
        .rxtx_oe_out(rxtx_oe_out), .uart_clock_off_in(uart_clock_off_in),
        .wake_request_out(wake_request_out), .irq_out(irq_out));
    uart_peer #(.bit_cycles(bc)) u_uart_peer (.mclk_in(mclk_in), .tx_line_in(tx_line),
        .line_out(peer_line), .got_out(got));
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    function automatic logic [7:0] next_rnd(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        exp_q.push_back(e);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
    endtask
    // the level is fetched after the wait, a registered irq needs two edges past its source
    task automatic flag(input string n, input logic e);
        logic s;
        repeat (5) @(posedge mclk_in);
        s = n == "irq_out" ? irq_out : n == "tx_oe_out" ? tx_oe_out
            : n == "rxtx_oe_out" ? rxtx_oe_out : wake_request_out;
        chk(n, {8'h00, e}, {8'h00, s});
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge mclk_in) begin
        rd_seen <= reg_rd_in;
        if (rd_seen) begin
            chk("reg_rdata_out", {1'b0, exp_q.pop_front()}, {1'b0, reg_rdata_out});
        end
    end
    // well above the roughly 700 cycles the sequence needs
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge mclk_in);
        srst_in <= 1'b0;
        rd(ctrl_two_addr, ctrl_two_reset);
        rd(3'h7, 8'h00);
        wr(ctrl_two_addr, 8'h80);
        flag("tx_oe_out", 1'b0);
        wr(ctrl_one_addr, 8'h80);
        // enables written while the uart is off are dropped, so write again
        wr(ctrl_two_addr, 8'h80);
        flag("tx_oe_out", 1'b1);
        for (int s = 0; s < 2; s++) begin
            wr(ctrl_two_addr, 8'h80 | (s[7:0] << 5));
            rnd = next_rnd(rnd);
            wr(data_addr, rnd);
            @(posedge mclk_in);
            wr(data_addr, ~rnd);
            // first capture stands only until the peer samples the second frame
            repeat (11 * bc) @(posedge mclk_in);
            chk("tx frame", {s[0], rnd}, got);
            repeat (25 * bc) @(posedge mclk_in);
        end
        for (int i = 1; i < 3; i++) begin
            wr(ctrl_two_addr, 8'h80 | i[7:0]);
            flag("irq_out", 1'b1);
        end
        wr(ctrl_one_addr, 8'h00);
        rd(ctrl_two_addr, 8'h02);
        wr(ctrl_one_addr, 8'h80);
        wr(ctrl_two_addr, 8'h00);
        flag("tx_oe_out", 1'b0);
        wr(ctrl_two_addr, 8'h40);
        rnd = next_rnd(rnd);
        u_uart_peer.send(rnd);
        flag("irq_out", 1'b0);
        wr(ctrl_two_addr, 8'h44);
        flag("irq_out", 1'b1);
        rd(data_addr, rnd);
        flag("irq_out", 1'b0);
        for (int a = 0; a < 2; a++) begin
            wr(ctrl_two_addr, 8'h54);
            d = {a[0], rnd[6:0]};
            u_uart_peer.send(d);
            flag("irq_out", a[0]);
        end
        rd(data_addr, d);
        wr(ctrl_three_addr, 8'h03);
        wr(ctrl_two_addr, 8'h80);
        flag("rxtx_oe_out", 1'b1);
        chk("rxtx_out", 9'h001, {8'h00, rxtx_out});
        wr(ctrl_two_addr, 8'hc0);
        flag("rxtx_oe_out", 1'b0);
        for (int w = 0; w < 3; w++) begin
            wr(ctrl_two_addr, w == 1 ? 8'h00 : 8'h08);
            uart_clock_off_in <= (w > 0);
            u_uart_peer.send(8'h00);
            flag("wake_request_out", w == 2);
        end
        chk("irq_out", 9'h001, {8'h00, irq_out});
        uart_clock_off_in <= 1'b0;
        conclude();
    end
endmodule
